// ===== smx_pkg.sv
// constants, state codes and helpers of the standby exit control block
`default_nettype none
package smx_pkg;
    // register index map
    localparam logic [3:0] SMX_ADDR_STBY_CTRL = 4'h0;
    localparam logic [3:0] SMX_ADDR_WDT_CS   = 4'h1;
    localparam logic [3:0] SMX_ADDR_WDT_CNT  = 4'h2;
    localparam logic [3:0] SMX_ADDR_INT_CTRL = 4'h3;
    localparam logic [3:0] SMX_ADDR_RST_CS   = 4'h4;
    localparam logic [3:0] SMX_ADDR_STATUS   = 4'h5;
    // standby control fields
    localparam int         SMX_SEL_BIT       = 7;
    localparam int         SMX_FLOAT_BIT     = 6;
    localparam logic [7:0] SMX_STBY_RESET    = 8'h1F;
    localparam logic [7:0] SMX_STBY_ONES     = 8'h1F;
    // watchdog control/status fields
    localparam int         SMX_OVF_BIT       = 7;
    localparam int         SMX_MODE_BIT      = 6;
    localparam int         SMX_RUN_BIT       = 5;
    localparam int         SMX_CKS_MSB       = 2;
    localparam logic [7:0] SMX_WDT_CS_RESET  = 8'h00;
    localparam logic [7:0] SMX_WDT_CLR_MASK  = 8'h1F;
    localparam logic [7:0] SMX_CNT_RESET     = 8'h00;
    localparam logic [7:0] SMX_CNT_LAST      = 8'hFF;
    localparam logic [7:0] SMX_RST_CS_RESET  = 8'h00;
    // interrupt control fields
    localparam int         SMX_EDGE_BIT      = 0;
    localparam logic       SMX_EDGE_FALL     = 1'h0;
    localparam logic [7:0] SMX_ZERO          = 8'h00;
    localparam logic [11:0] SMX_PRE_RESET    = 12'h000;
    localparam logic [11:0] SMX_PRE_BASE     = 12'h002;
    localparam logic [11:0] SMX_PRE_ONE      = 12'h001;
    localparam logic [7:0] SMX_CNT_ONE       = 8'h01;

    typedef enum logic [3:0] {
        SMX_RUN     = 4'h1,
        SMX_SLEEP   = 4'h2,
        SMX_STANDBY = 4'h4,
        SMX_WAKE    = 4'h8
    } smx_state_t;

    // last prescaler value for a clock select code: divide by 2 << sel
    function automatic logic [11:0] smx_div_last(input logic [2:0] sel);
        return (SMX_PRE_BASE << sel) - SMX_PRE_ONE;
    endfunction
endpackage
`default_nettype wire

// ===== smx_wdt_if.sv
// carrier between the sequencer and the watchdog counter
`timescale 1ns/1ps
`default_nettype none
interface smx_wdt_if;
    logic       countRun;
    logic [2:0] clockSelect;
    logic       load;
    logic [7:0] loadValue;
    logic [7:0] count;
    logic       overflow;
    modport ctrl  (output countRun, clockSelect, load, loadValue, input count, overflow);
    modport timer (input countRun, clockSelect, load, loadValue, output count, overflow);
endinterface
`default_nettype wire

// ===== smx_wdt_counter.sv
// watchdog count with clock-select prescaler
`timescale 1ns/1ps
`default_nettype none
module smx_wdt_counter (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    // sequencer side
    smx_wdt_if.timer wdt
);
    logic [11:0] prescale_reg;
    logic        tick;

    assign tick = wdt.countRun && (prescale_reg == smx_pkg::smx_div_last(wdt.clockSelect));

    always_ff @(posedge clock) begin
        if (reset) begin
            prescale_reg <= smx_pkg::SMX_PRE_RESET;
        end else if (clockEnable) begin
            if (wdt.load || tick || !wdt.countRun) begin
                prescale_reg <= smx_pkg::SMX_PRE_RESET;
            end else begin
                prescale_reg <= prescale_reg + smx_pkg::SMX_PRE_ONE;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            wdt.count    <= smx_pkg::SMX_CNT_RESET;
            wdt.overflow <= 1'b0;
        end else if (clockEnable) begin
            wdt.overflow <= 1'b0;
            if (wdt.load) begin
                wdt.count <= wdt.loadValue;
            end else if (tick) begin
                wdt.count    <= wdt.count + smx_pkg::SMX_CNT_ONE;
                wdt.overflow <= (wdt.count == smx_pkg::SMX_CNT_LAST);
            end
        end
    end
endmodule // smx_wdt_counter
`default_nettype wire

// ===== smx_pin_watch.sv
// edge watch on the nmi and reset pins
`timescale 1ns/1ps
`default_nettype none
module smx_pin_watch (
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    input wire logic clockEnable,
    // pins
    input wire logic nmiPin,
    input wire logic resetPinN,
    // events
    output logic     nmiRise,
    output logic     nmiFall,
    output logic     resetFall,
    output logic     resetNmiHigh
);
    logic nmiPrev_reg;
    logic resetPrevN_reg;

    // history follows the pins through reset, so release shows no false edge
    always_ff @(posedge clock) begin
        if (reset) begin
            nmiPrev_reg    <= nmiPin;
            resetPrevN_reg <= resetPinN;
            nmiRise        <= 1'b0;
            nmiFall        <= 1'b0;
            resetFall      <= 1'b0;
            resetNmiHigh   <= 1'b0;
        end else if (clockEnable) begin
            nmiPrev_reg    <= nmiPin;
            resetPrevN_reg <= resetPinN;
            nmiRise        <= nmiPin && !nmiPrev_reg;
            nmiFall        <= !nmiPin && nmiPrev_reg;
            resetFall      <= !resetPinN && resetPrevN_reg;
            resetNmiHigh   <= nmiPin;
        end
    end
endmodule // smx_pin_watch
`default_nettype wire

// ===== smx_standby_ctrl.sv
// standby entry, register retention and standby exit sequencer
// Behaviour
// - sleep with standby select enters standby
// - standby select refused while watchdog runs
// - port float bit floats ports in standby
// - interrupt, break, bus, pin units hold
// - dma unit registers reinitialised on entry
// - watchdog bits 7-5, reset status cleared
// - timer pulse unit reinitialised on entry
// - timing pattern unit holds its registers
// - serial unit registers reinitialised on entry
// - standby control register kept through standby
// - only nmi or reset ends standby
// - nmi edge restarts clock, watchdog only
// - watchdog overflow ends standby, nmi exception
// - reset low, nmi high: power-on reset
// - edge select defaults to falling edge
// - reset low, nmi low: manual reset
// - reset low ends standby ahead of a simultaneous nmi edge
`timescale 1ns/1ps
`default_nettype none
module smx_standby_ctrl (
    // clock and reset
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        clockEnable,
    // register port
    input wire logic [3:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    output logic     [7:0]  regRdData,
    // cpu and pins
    input wire logic        sleepExec,
    input wire logic        nmiPin,
    input wire logic        resetPinN,
    // clocks and port state
    output logic            chipClockOn,
    output logic            wdtClockOn,
    output logic            portFloat,
    output logic            standbyActive,
    output logic            sleepActive,
    output logic            retainHold,
    // one-cycle events
    output logic            dmaInit,
    output logic            timerInit,
    output logic            serialInit,
    output logic            nmiException,
    output logic            powerOnReset,
    output logic            manualReset
);
    smx_pkg::smx_state_t state_reg;
    smx_pkg::smx_state_t state_next;
    logic [7:0] stbyCtrl_reg;
    logic [7:0] wdtCs_reg;
    logic [7:0] intCtrl_reg;
    logic [7:0] rstCs_reg;
    logic       nmiRise;
    logic       nmiFall;
    logic       resetFall;
    logic       resetNmiHigh;
    logic       wakeEdge;
    logic       enterStandby;
    logic       wdtRun;
    logic       wrStby;
    logic       wrWdt;
    logic       wrCnt;

    smx_wdt_if wdtBus ();

    smx_wdt_counter wdtCounter (
        .clock       (clock),
        .reset       (reset),
        .clockEnable (clockEnable),
        .wdt         (wdtBus.timer)
    );

    smx_pin_watch pinWatch (
        .clock        (clock),
        .reset        (reset),
        .clockEnable  (clockEnable),
        .nmiPin       (nmiPin),
        .resetPinN    (resetPinN),
        .nmiRise      (nmiRise),
        .nmiFall      (nmiFall),
        .resetFall    (resetFall),
        .resetNmiHigh (resetNmiHigh)
    );

    assign wdtRun       = wdtCs_reg[smx_pkg::SMX_RUN_BIT];
    assign wrStby       = regWrite && (regAddr == smx_pkg::SMX_ADDR_STBY_CTRL);
    assign wrWdt        = regWrite && (regAddr == smx_pkg::SMX_ADDR_WDT_CS);
    assign wrCnt        = regWrite && (regAddr == smx_pkg::SMX_ADDR_WDT_CNT);
    assign enterStandby = (state_reg == smx_pkg::SMX_RUN) && sleepExec
                          && stbyCtrl_reg[smx_pkg::SMX_SEL_BIT];
    // edge select stands at falling after reset; a handler may pick rising
    assign wakeEdge     = intCtrl_reg[smx_pkg::SMX_EDGE_BIT] ? nmiRise : nmiFall;

    // mode sequencing: reset pin outranks a simultaneous nmi edge
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            smx_pkg::SMX_RUN: begin
                if (sleepExec) begin
                    state_next = stbyCtrl_reg[smx_pkg::SMX_SEL_BIT]
                                 ? smx_pkg::SMX_STANDBY : smx_pkg::SMX_SLEEP;
                end
            end
            smx_pkg::SMX_SLEEP: begin
                if (resetFall || nmiRise || nmiFall) begin
                    state_next = smx_pkg::SMX_RUN;
                end
            end
            smx_pkg::SMX_STANDBY: begin
                if (resetFall) begin
                    state_next = smx_pkg::SMX_RUN;
                end else if (wakeEdge) begin
                    state_next = smx_pkg::SMX_WAKE;
                end
            end
            smx_pkg::SMX_WAKE: begin
                if (resetFall || wdtBus.overflow) begin
                    state_next = smx_pkg::SMX_RUN;
                end
            end
            default: state_next = smx_pkg::SMX_RUN;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= smx_pkg::SMX_RUN;
        end else if (clockEnable) begin
            state_reg <= state_next;
        end
    end

    // standby control: only software writes it, standby never touches it
    always_ff @(posedge clock) begin
        if (reset) begin
            stbyCtrl_reg <= smx_pkg::SMX_STBY_RESET;
        end else if (clockEnable && wrStby) begin
            stbyCtrl_reg <= smx_pkg::SMX_STBY_ONES;
            stbyCtrl_reg[smx_pkg::SMX_SEL_BIT] <= regWrData[smx_pkg::SMX_SEL_BIT]
                && (!wdtRun || stbyCtrl_reg[smx_pkg::SMX_SEL_BIT]);
            stbyCtrl_reg[smx_pkg::SMX_FLOAT_BIT] <= regWrData[smx_pkg::SMX_FLOAT_BIT]
                && (!wdtRun || stbyCtrl_reg[smx_pkg::SMX_FLOAT_BIT]);
        end
    end

    // watchdog control/status; overflow set beats a software clear
    always_ff @(posedge clock) begin
        if (reset) begin
            wdtCs_reg <= smx_pkg::SMX_WDT_CS_RESET;
        end else if (clockEnable) begin
            if (enterStandby) begin
                wdtCs_reg <= wdtCs_reg & smx_pkg::SMX_WDT_CLR_MASK;
            end else begin
                if (wrWdt) begin
                    wdtCs_reg[smx_pkg::SMX_MODE_BIT] <= regWrData[smx_pkg::SMX_MODE_BIT];
                    wdtCs_reg[smx_pkg::SMX_RUN_BIT]  <= regWrData[smx_pkg::SMX_RUN_BIT];
                    wdtCs_reg[smx_pkg::SMX_CKS_MSB:0] <= regWrData[smx_pkg::SMX_CKS_MSB:0];
                    if (!regWrData[smx_pkg::SMX_OVF_BIT]) begin
                        wdtCs_reg[smx_pkg::SMX_OVF_BIT] <= 1'b0;
                    end
                end
                if (wdtBus.overflow && wdtRun) begin
                    wdtCs_reg[smx_pkg::SMX_OVF_BIT] <= 1'b1;
                end
            end
        end
    end

    // reset control/status and interrupt control
    always_ff @(posedge clock) begin
        if (reset) begin
            rstCs_reg <= smx_pkg::SMX_RST_CS_RESET;
        end else if (clockEnable) begin
            if (enterStandby) begin
                rstCs_reg <= smx_pkg::SMX_RST_CS_RESET;
            end else if (regWrite && (regAddr == smx_pkg::SMX_ADDR_RST_CS)) begin
                rstCs_reg <= regWrData;
            end
        end
    end

    localparam logic [7:0] SMX_INT_MASK = 8'h01;
    always_ff @(posedge clock) begin
        if (reset) begin
            intCtrl_reg <= smx_pkg::SMX_ZERO;
            intCtrl_reg[smx_pkg::SMX_EDGE_BIT] <= smx_pkg::SMX_EDGE_FALL;
        end else if (clockEnable && regWrite && (regAddr == smx_pkg::SMX_ADDR_INT_CTRL)) begin
            intCtrl_reg <= SMX_INT_MASK & regWrData;
        end
    end

    // count keeps its value across entry; runs in run or sleep mode while the run bit is set, and always during wake
    assign wdtBus.countRun    = (state_reg == smx_pkg::SMX_WAKE)
                                || (wdtRun && (state_reg != smx_pkg::SMX_STANDBY));
    assign wdtBus.clockSelect = wdtCs_reg[smx_pkg::SMX_CKS_MSB:0];
    assign wdtBus.load        = clockEnable && wrCnt;
    assign wdtBus.loadValue   = regWrData;

    // register read data, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (reset) begin
            regRdData <= smx_pkg::SMX_ZERO;
        end else if (clockEnable) begin
            regRdData <= smx_pkg::SMX_ZERO;
            if (regRead) begin
                case (regAddr)
                    smx_pkg::SMX_ADDR_STBY_CTRL: regRdData <= stbyCtrl_reg;
                    smx_pkg::SMX_ADDR_WDT_CS:   regRdData <= wdtCs_reg;
                    smx_pkg::SMX_ADDR_WDT_CNT:  regRdData <= wdtBus.count;
                    smx_pkg::SMX_ADDR_INT_CTRL: regRdData <= intCtrl_reg;
                    smx_pkg::SMX_ADDR_RST_CS:   regRdData <= rstCs_reg;
                    smx_pkg::SMX_ADDR_STATUS:   regRdData <= {4'h0, state_reg};
                    default:                    regRdData <= smx_pkg::SMX_ZERO;
                endcase
            end
        end
    end

    // clock gating and port state follow the next state
    always_ff @(posedge clock) begin
        if (reset) begin
            chipClockOn   <= 1'b1;
            wdtClockOn    <= 1'b1;
            standbyActive <= 1'b0;
            sleepActive   <= 1'b0;
            portFloat     <= 1'b0;
            retainHold    <= 1'b0;
        end else if (clockEnable) begin
            chipClockOn   <= (state_next == smx_pkg::SMX_RUN) || (state_next == smx_pkg::SMX_SLEEP);
            wdtClockOn    <= state_next != smx_pkg::SMX_STANDBY;
            standbyActive <= (state_next == smx_pkg::SMX_STANDBY) || (state_next == smx_pkg::SMX_WAKE);
            sleepActive   <= state_next == smx_pkg::SMX_SLEEP;
            portFloat     <= ((state_next == smx_pkg::SMX_STANDBY) || (state_next == smx_pkg::SMX_WAKE))
                             && stbyCtrl_reg[smx_pkg::SMX_FLOAT_BIT];
            // interrupt, break, bus, pin, port and pattern units just freeze
            retainHold    <= (state_next == smx_pkg::SMX_STANDBY) || (state_next == smx_pkg::SMX_WAKE);
        end
    end

    // one-cycle events
    always_ff @(posedge clock) begin
        if (reset) begin
            dmaInit      <= 1'b0;
            timerInit    <= 1'b0;
            serialInit   <= 1'b0;
            nmiException <= 1'b0;
            powerOnReset <= 1'b0;
            manualReset  <= 1'b0;
        end else if (clockEnable) begin
            dmaInit      <= enterStandby;
            timerInit    <= enterStandby;
            serialInit   <= enterStandby;
            nmiException <= (state_reg == smx_pkg::SMX_WAKE) && !resetFall && wdtBus.overflow;
            powerOnReset <= (state_reg != smx_pkg::SMX_RUN) && resetFall && resetNmiHigh;
            manualReset  <= (state_reg != smx_pkg::SMX_RUN) && resetFall && !resetNmiHigh;
        end
    end

    // checks
    sequence seq_entry;
        clockEnable && enterStandby;
    endsequence

    sequence seq_wake_exit;
        clockEnable && (state_reg == smx_pkg::SMX_WAKE) && wdtBus.overflow && !resetFall;
    endsequence

    chk_stby_refused: assert property (@(posedge clock) disable iff (reset)
        clockEnable && wrStby && wdtRun && regWrData[smx_pkg::SMX_SEL_BIT] && !stbyCtrl_reg[smx_pkg::SMX_SEL_BIT]
        |=> !stbyCtrl_reg[smx_pkg::SMX_SEL_BIT])
        else $error("standby select set while watchdog runs");

    chk_entry_standby: assert property (@(posedge clock) disable iff (reset)
        seq_entry |=> (state_reg == smx_pkg::SMX_STANDBY) && !chipClockOn && !wdtClockOn && standbyActive)
        else $error("standby not entered");

    chk_port_float: assert property (@(posedge clock) disable iff (reset)
        seq_entry |=> portFloat == stbyCtrl_reg[smx_pkg::SMX_FLOAT_BIT])
        else $error("port float wrong in standby");

    chk_init_pulse: assert property (@(posedge clock) disable iff (reset)
        seq_entry ##1 clockEnable |=> dmaInit == 1'b0 && $past(dmaInit) && $past(serialInit) && $past(timerInit))
        else $error("init pulse not one cycle");

    chk_wdt_init: assert property (@(posedge clock) disable iff (reset)
        seq_entry |=> (wdtCs_reg[smx_pkg::SMX_OVF_BIT:smx_pkg::SMX_RUN_BIT] == 3'h0)
        && (wdtCs_reg[smx_pkg::SMX_CKS_MSB:0] == $past(wdtCs_reg[smx_pkg::SMX_CKS_MSB:0]))
        && (rstCs_reg == smx_pkg::SMX_RST_CS_RESET) && (wdtBus.count == $past(wdtBus.count)))
        else $error("watchdog bits wrong after entry");

    chk_ctrl_kept: assert property (@(posedge clock) disable iff (reset)
        (state_reg == smx_pkg::SMX_STANDBY) && !wrStby |=> $stable(stbyCtrl_reg))
        else $error("standby control changed in standby");

    chk_no_other_exit: assert property (@(posedge clock) disable iff (reset)
        (state_reg == smx_pkg::SMX_STANDBY) && !wakeEdge && !resetFall |=> state_reg == smx_pkg::SMX_STANDBY)
        else $error("standby left without cause");

    chk_wake_start: assert property (@(posedge clock) disable iff (reset)
        clockEnable && (state_reg == smx_pkg::SMX_STANDBY) && wakeEdge && !resetFall
        |=> (state_reg == smx_pkg::SMX_WAKE) && wdtClockOn && !chipClockOn)
        else $error("wake did not start watchdog clock");

    chk_wake_exit: assert property (@(posedge clock) disable iff (reset)
        seq_wake_exit |=> nmiException && chipClockOn && (state_reg == smx_pkg::SMX_RUN))
        else $error("overflow did not end standby");

    chk_reset_kind: assert property (@(posedge clock) disable iff (reset)
        clockEnable && (state_reg == smx_pkg::SMX_STANDBY) && resetFall
        |=> (powerOnReset == $past(resetNmiHigh)) && (manualReset == !$past(resetNmiHigh)))
        else $error("wrong reset kind on standby exit");

    chk_freeze_state: assert property (@(posedge clock) disable iff (reset)
        !clockEnable |=> $stable(state_reg) && $stable(stbyCtrl_reg) && $stable(regRdData))
        else $error("state moved while clock enable low");

    chk_init_quiet: assert property (@(posedge clock) disable iff (reset)
        clockEnable && !enterStandby |=> !dmaInit && !timerInit && !serialInit)
        else $error("init pulse without standby entry");

    chk_sleep_entry: assert property (@(posedge clock) disable iff (reset)
        clockEnable && (state_reg == smx_pkg::SMX_RUN) && sleepExec && !stbyCtrl_reg[smx_pkg::SMX_SEL_BIT]
        |=> (state_reg == smx_pkg::SMX_SLEEP) && sleepActive && chipClockOn && !standbyActive && !dmaInit)
        else $error("sleep not entered");

    chk_rise_ignored: assert property (@(posedge clock) disable iff (reset)
        clockEnable && (state_reg == smx_pkg::SMX_STANDBY) && !nmiFall && !resetFall
        && (intCtrl_reg[smx_pkg::SMX_EDGE_BIT] == smx_pkg::SMX_EDGE_FALL) |=> state_reg == smx_pkg::SMX_STANDBY)
        else $error("standby left without falling nmi");

    chk_ovf_flag: assert property (@(posedge clock) disable iff (reset)
        clockEnable && !enterStandby && wdtBus.overflow && wdtRun |=> wdtCs_reg[smx_pkg::SMX_OVF_BIT])
        else $error("overflow flag not set");
endmodule // smx_standby_ctrl
`default_nettype wire

// ===== smx_pin_source.sv
// far-side model: sources of the nmi and reset pins
`timescale 1ns/1ps
`default_nettype none
module smx_pin_source (
    // clock
    input wire logic clock,
    // levels asked for by the bench
    input wire logic nmiLevel,
    input wire logic resetLevelN,
    // pins
    output logic     nmiPin,
    output logic     resetPinN
);
    // pins move only just after an edge, as a synchronous source would
    always_ff @(posedge clock) begin
        nmiPin    <= nmiLevel;
        resetPinN <= resetLevelN;
    end
endmodule // smx_pin_source
`default_nettype wire

// ===== smx_tb.sv
// self-checking bench of the standby exit sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clock, reset, clockEnable, regWrite, regRead, sleepExec, nmiLevel, resetLevelN, nmiPin, resetPinN;
    logic [3:0] regAddr;
    logic [7:0] regWrData, regRdData;
    logic       chipClockOn, wdtClockOn, portFloat, standbyActive, sleepActive, retainHold;
    logic       dmaInit, timerInit, serialInit, nmiException, powerOnReset, manualReset;
    int         failures, comparisons, cycles, n;

    smx_standby_ctrl dut (.clock(clock), .reset(reset), .clockEnable(clockEnable), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .sleepExec(sleepExec), .nmiPin(nmiPin), .resetPinN(resetPinN), .chipClockOn(chipClockOn),
        .wdtClockOn(wdtClockOn), .portFloat(portFloat), .standbyActive(standbyActive),
        .sleepActive(sleepActive), .retainHold(retainHold), .dmaInit(dmaInit), .timerInit(timerInit),
        .serialInit(serialInit), .nmiException(nmiException), .powerOnReset(powerOnReset),
        .manualReset(manualReset));
    smx_pin_source pins (.clock(clock), .nmiLevel(nmiLevel), .resetLevelN(resetLevelN),
        .nmiPin(nmiPin), .resetPinN(resetPinN));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic complete_run;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            complete_run();
        end
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input string what, input logic [3:0] a, input logic [7:0] exp);
        @(posedge clock);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clock);
        regRead <= 1'b0;
        #1;
        chk8(what, exp, regRdData);
    endtask

    task automatic sleep;
        @(posedge clock);
        sleepExec <= 1'b1;
        @(posedge clock);
        sleepExec <= 1'b0;
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return standbyActive;
            1: return wdtClockOn;
            2: return nmiException;
            3: return manualReset;
            4: return powerOnReset;
            default: return sleepActive;
        endcase
    endfunction

    // bounded wait; checks the current cycle first so one-cycle pulses are not missed
    task automatic waitSig(input int k);
        n = 0;
        #1;
        while (pick(k) !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk1("awaited", 1'b1, pick(k));
    endtask

    initial begin
        reset = 1'b1;
        clockEnable = 1'b1;
        regAddr = 4'h0;
        regWrData = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        sleepExec = 1'b0;
        nmiLevel = 1'b1;
        resetLevelN = 1'b1;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        n = 0;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        rd("stbyCtrl", 4'h0, 8'h1F);
        rd("wdtCs", 4'h1, 8'h00);
        rd("rstCs", 4'h4, 8'h00);
        rd("status", 4'h5, 8'h01);
        rd("unmapped", 4'h9, 8'h00);
        chk1("chipClockOn", 1'b1, chipClockOn);
        // a write while the enable is low must be lost
        @(posedge clock) clockEnable <= 1'b0;
        wr(4'h0, 8'hC0);
        @(posedge clock) clockEnable <= 1'b1;
        rd("frozen", 4'h0, 8'h1F);
        wr(4'h1, 8'h20);
        wr(4'h0, 8'hC0);
        rd("stbyRefused", 4'h0, 8'h1F);
        wr(4'h1, 8'h43);
        wr(4'h4, 8'h55);
        wr(4'h2, 8'hFF);
        wr(4'h0, 8'hC0);
        rd("stbyTaken", 4'h0, 8'hDF);
        rd("rstCsSet", 4'h4, 8'h55);
        sleep();
        waitSig(0);
        chk1("dmaInit", 1'b1, dmaInit);
        chk1("timerInit", 1'b1, timerInit);
        chk1("serialInit", 1'b1, serialInit);
        chk1("portFloat", 1'b1, portFloat);
        chk1("chipOff", 1'b0, chipClockOn);
        chk1("wdtOff", 1'b0, wdtClockOn);
        chk1("retainHold", 1'b1, retainHold);
        rd("statusStby", 4'h5, 8'h04);
        sleep();
        repeat (4) @(posedge clock);
        #1 chk1("stillStandby", 1'b1, standbyActive);
        @(posedge clock) nmiLevel <= 1'b0;
        waitSig(1);
        chk1("chipStillOff", 1'b0, chipClockOn);
        waitSig(2);
        chk1("chipOn", 1'b1, chipClockOn);
        chk1("standbyLeft", 1'b0, standbyActive);
        // clock select 3 gives 16 cycles a count step
        chk1("settleLong", 1'b1, n >= 8);
        rd("wdtCsAfter", 4'h1, 8'h03);
        rd("rstCsAfter", 4'h4, 8'h00);
        rd("stbyKept", 4'h0, 8'hDF);
        wr(4'h3, 8'h01);
        // count wrapped on the last wake; reload so the next wake stays short
        wr(4'h2, 8'hFF);
        sleep();
        waitSig(0);
        @(posedge clock) nmiLevel <= 1'b1;
        waitSig(2);
        wr(4'h3, 8'h00);
        sleep();
        waitSig(0);
        @(posedge clock) nmiLevel <= 1'b0;
        waitSig(1);
        @(posedge clock) resetLevelN <= 1'b0;
        waitSig(3);
        chk1("porQuiet", 1'b0, powerOnReset);
        @(posedge clock) resetLevelN <= 1'b1;
        repeat (4) @(posedge clock);
        wr(4'h0, 8'hC0);
        wr(4'h3, 8'h00);
        sleep();
        waitSig(0);
        @(posedge clock) nmiLevel <= 1'b1;
        repeat (6) @(posedge clock);
        #1 chk1("riseNoWake", 1'b0, wdtClockOn);
        @(posedge clock) resetLevelN <= 1'b0;
        waitSig(4);
        chk1("manQuiet", 1'b0, manualReset);
        @(posedge clock) resetLevelN <= 1'b1;
        repeat (4) @(posedge clock);
        wr(4'h0, 8'h00);
        sleep();
        waitSig(5);
        chk1("sleepClock", 1'b1, chipClockOn);
        chk1("sleepNotStandby", 1'b0, standbyActive);
        @(posedge clock) nmiLevel <= 1'b0;
        repeat (4) @(posedge clock);
        #1 chk1("sleepLeft", 1'b0, sleepActive);
        // watchdog running in run mode: overflow raises the flag
        wr(4'h2, 8'hFF);
        wr(4'h1, 8'h20);
        repeat (4) @(posedge clock);
        rd("ovfSet", 4'h1, 8'hA0);
        complete_run();
    end
endmodule // tb
`default_nettype wire
